// *** iep_irq_regs.sv ***
// Summary of operation
// - Enable register bit 6 passes or masks USB interrupts.
// - Enable register bit 4 passes or masks keypad interrupts.
// - Enable register bit 2 passes or masks serial peripheral interrupts.
// - Enable register bit 1 passes or masks two-wire interrupts.
// - Enable register bit 0 passes or masks card interrupts.
// - Unused bits 7, 5, 3 of group-one registers read zero; software writes zero.
// - Group-one enable register sits at B1h.
// - Group-zero priority MSBs sit at B7h; bit 7 unused.
// - Group-one priority MSBs sit at B3h.
// - Global enable gates every source.
// - Group-zero priority LSBs come from B8h, same bit positions.
// - Group-one priority LSBs come from B2h, same bit positions.
`timescale 1ns/1ps
`default_nettype none

module iep_irq_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_rhit,
  input wire logic global_irq_enable,
  input wire logic [6:0] group0_irq_enable,
  input wire logic [7:0] prio_lsb_group0,
  input wire logic [7:0] prio_lsb_group1,
  input wire logic [6:0] group0_req,
  input wire logic [7:0] group1_req,
  input wire logic [iep_pkg::NUM_LEVELS-1:0] svc_active,
  output logic [7:0] irq_enable_group1_out,
  output logic [7:0] prio_msb_group0_out,
  output logic [7:0] prio_msb_group1_out,
  output logic irq_pending,
  output logic [iep_pkg::SLOT_W-1:0] irq_slot,
  output logic [iep_pkg::LEVEL_W-1:0] irq_level
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] irq_enable_group1;
  logic [7:0] irq_priority_msb_group1;
  logic [7:0] irq_priority_msb_group0;

  logic usb_irq_enable;
  logic keypad_irq_enable;
  logic serial_periph_irq_enable;
  logic two_wire_irq_enable;
  logic card_irq_enable;

  iep_arb_if arb_bus ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One select per register so every write path sees the same decode
  logic sel_enable1;
  logic sel_msb1;
  logic sel_msb0;
  logic wr_enable1;
  logic wr_msb1;
  logic wr_msb0;

  assign sel_enable1 = (sfr_addr == iep_pkg::IRQ_EN1_ADDR);
  assign sel_msb1 = (sfr_addr == iep_pkg::PRIO_MSB1_ADDR);
  assign sel_msb0 = (sfr_addr == iep_pkg::PRIO_MSB0_ADDR);
  assign wr_enable1 = sfr_wr && sel_enable1;
  assign wr_msb1 = sfr_wr && sel_msb1;
  assign wr_msb0 = sfr_wr && sel_msb0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_enable_group1 <= iep_pkg::REG_RESET;
    end else if (wr_enable1) begin
      // Unused positions never store, so they always read zero
      irq_enable_group1 <= sfr_wdata & iep_pkg::GROUP1_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_priority_msb_group1 <= iep_pkg::REG_RESET;
    end else if (wr_msb1) begin
      irq_priority_msb_group1 <= sfr_wdata & iep_pkg::GROUP1_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_priority_msb_group0 <= iep_pkg::REG_RESET;
    end else if (wr_msb0) begin
      // Bit 7 is left unbuilt; it reads zero, a legal case of indeterminate
      irq_priority_msb_group0 <= sfr_wdata & iep_pkg::GROUP0_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data lands one cycle after the strobe so the core mux sees a register
  // A read and a write in one cycle return the contents from before the write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= iep_pkg::REG_RESET;
      sfr_rhit <= 1'b0;
    end else begin
      sfr_rhit <= 1'b0;
      sfr_rdata <= iep_pkg::REG_RESET;
      if (sfr_rd) begin
        unique case (sfr_addr)
          iep_pkg::IRQ_EN1_ADDR: begin
            sfr_rdata <= irq_enable_group1;
            sfr_rhit <= 1'b1;
          end
          iep_pkg::PRIO_MSB1_ADDR: begin
            sfr_rdata <= irq_priority_msb_group1;
            sfr_rhit <= 1'b1;
          end
          iep_pkg::PRIO_MSB0_ADDR: begin
            sfr_rdata <= irq_priority_msb_group0;
            sfr_rhit <= 1'b1;
          end
          default: begin
            sfr_rhit <= 1'b0;
          end
        endcase
      end
    end
  end

  assign irq_enable_group1_out = irq_enable_group1;
  assign prio_msb_group0_out = irq_priority_msb_group0;
  assign prio_msb_group1_out = irq_priority_msb_group1;

  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  assign usb_irq_enable = irq_enable_group1[iep_pkg::USB_BIT];
  assign keypad_irq_enable = irq_enable_group1[iep_pkg::KEYPAD_BIT];
  assign serial_periph_irq_enable = irq_enable_group1[iep_pkg::SERIAL_PERIPH_BIT];
  assign two_wire_irq_enable = irq_enable_group1[iep_pkg::TWO_WIRE_BIT];
  assign card_irq_enable = irq_enable_group1[iep_pkg::CARD_BIT];

  // Level is MSB from here and LSB from the neighbouring register
  function automatic logic [iep_pkg::LEVEL_W-1:0] iep_lvl(input logic msb, input logic lsb);
    return {msb, lsb};
  endfunction

  // Slots 11, 12, 14 and 15 carry no source; their requests stay low
  always_comb begin
    arb_bus.req = '0;
    arb_bus.level = '0;
    arb_bus.svc_active = svc_active;
    if (global_irq_enable) begin
      arb_bus.req[iep_pkg::SLOT_EXTINT0] = group0_req[iep_pkg::EXTINT0_BIT] & group0_irq_enable[iep_pkg::EXTINT0_BIT];
      arb_bus.req[iep_pkg::SLOT_TIMER0] = group0_req[iep_pkg::TIMER0_BIT] & group0_irq_enable[iep_pkg::TIMER0_BIT];
      arb_bus.req[iep_pkg::SLOT_EXTINT1] = group0_req[iep_pkg::EXTINT1_BIT] & group0_irq_enable[iep_pkg::EXTINT1_BIT];
      arb_bus.req[iep_pkg::SLOT_TIMER1] = group0_req[iep_pkg::TIMER1_BIT] & group0_irq_enable[iep_pkg::TIMER1_BIT];
      arb_bus.req[iep_pkg::SLOT_UART] = group0_req[iep_pkg::UART_BIT] & group0_irq_enable[iep_pkg::UART_BIT];
      arb_bus.req[iep_pkg::SLOT_DECODER] = group0_req[iep_pkg::DECODER_BIT] & group0_irq_enable[iep_pkg::DECODER_BIT];
      arb_bus.req[iep_pkg::SLOT_AUDIO] = group0_req[iep_pkg::AUDIO_BIT] & group0_irq_enable[iep_pkg::AUDIO_BIT];
      arb_bus.req[iep_pkg::SLOT_USB] = group1_req[iep_pkg::USB_BIT] & usb_irq_enable;
      arb_bus.req[iep_pkg::SLOT_KEYPAD] = group1_req[iep_pkg::KEYPAD_BIT] & keypad_irq_enable;
      arb_bus.req[iep_pkg::SLOT_SERIAL_PERIPH] =
        group1_req[iep_pkg::SERIAL_PERIPH_BIT] & serial_periph_irq_enable;
      arb_bus.req[iep_pkg::SLOT_TWO_WIRE] = group1_req[iep_pkg::TWO_WIRE_BIT] & two_wire_irq_enable;
      arb_bus.req[iep_pkg::SLOT_CARD] = group1_req[iep_pkg::CARD_BIT] & card_irq_enable;
    end
    arb_bus.level[iep_pkg::SLOT_EXTINT0] = iep_lvl(irq_priority_msb_group0[iep_pkg::EXTINT0_BIT],
      prio_lsb_group0[iep_pkg::EXTINT0_BIT]);
    arb_bus.level[iep_pkg::SLOT_TIMER0] = iep_lvl(irq_priority_msb_group0[iep_pkg::TIMER0_BIT],
      prio_lsb_group0[iep_pkg::TIMER0_BIT]);
    arb_bus.level[iep_pkg::SLOT_EXTINT1] = iep_lvl(irq_priority_msb_group0[iep_pkg::EXTINT1_BIT],
      prio_lsb_group0[iep_pkg::EXTINT1_BIT]);
    arb_bus.level[iep_pkg::SLOT_TIMER1] = iep_lvl(irq_priority_msb_group0[iep_pkg::TIMER1_BIT],
      prio_lsb_group0[iep_pkg::TIMER1_BIT]);
    arb_bus.level[iep_pkg::SLOT_UART] = iep_lvl(irq_priority_msb_group0[iep_pkg::UART_BIT],
      prio_lsb_group0[iep_pkg::UART_BIT]);
    arb_bus.level[iep_pkg::SLOT_DECODER] = iep_lvl(irq_priority_msb_group0[iep_pkg::DECODER_BIT],
      prio_lsb_group0[iep_pkg::DECODER_BIT]);
    arb_bus.level[iep_pkg::SLOT_AUDIO] = iep_lvl(irq_priority_msb_group0[iep_pkg::AUDIO_BIT],
      prio_lsb_group0[iep_pkg::AUDIO_BIT]);
    arb_bus.level[iep_pkg::SLOT_USB] = iep_lvl(irq_priority_msb_group1[iep_pkg::USB_BIT],
      prio_lsb_group1[iep_pkg::USB_BIT]);
    arb_bus.level[iep_pkg::SLOT_KEYPAD] = iep_lvl(irq_priority_msb_group1[iep_pkg::KEYPAD_BIT],
      prio_lsb_group1[iep_pkg::KEYPAD_BIT]);
    arb_bus.level[iep_pkg::SLOT_SERIAL_PERIPH] = iep_lvl(irq_priority_msb_group1[iep_pkg::SERIAL_PERIPH_BIT],
      prio_lsb_group1[iep_pkg::SERIAL_PERIPH_BIT]);
    arb_bus.level[iep_pkg::SLOT_TWO_WIRE] = iep_lvl(irq_priority_msb_group1[iep_pkg::TWO_WIRE_BIT],
      prio_lsb_group1[iep_pkg::TWO_WIRE_BIT]);
    arb_bus.level[iep_pkg::SLOT_CARD] = iep_lvl(irq_priority_msb_group1[iep_pkg::CARD_BIT],
      prio_lsb_group1[iep_pkg::CARD_BIT]);
  end

  iep_arbiter u_arb (
    .arb(arb_bus.arb)
  );

  // ----------------------------------------------------------------
  // Request to the core
  // ----------------------------------------------------------------
  // Registered so a long arbitration path never reaches the core fetch logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_pending <= 1'b0;
      irq_slot <= '0;
      irq_level <= '0;
    end else begin
      irq_pending <= arb_bus.grant;
      irq_slot <= arb_bus.slot;
      irq_level <= arb_bus.grant_level;
    end
  end

endmodule

`default_nettype wire

// *** iep_pkg.sv ***
package iep_pkg;

  // ----------------------------------------------------------------
  // Register addresses in the special-function space
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_EN1_ADDR = 8'hb1;
  localparam logic [7:0] PRIO_MSB1_ADDR = 8'hb3;
  localparam logic [7:0] PRIO_MSB0_ADDR = 8'hb7;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int USB_BIT = 6;
  localparam int KEYPAD_BIT = 4;
  localparam int SERIAL_PERIPH_BIT = 2;
  localparam int TWO_WIRE_BIT = 1;
  localparam int CARD_BIT = 0;
  localparam int AUDIO_BIT = 6;
  localparam int DECODER_BIT = 5;
  localparam int UART_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXTINT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXTINT0_BIT = 0;

  // Implemented bits; all others read as zero
  localparam logic [7:0] GROUP1_MASK = 8'h57;
  localparam logic [7:0] GROUP0_MASK = 8'h7f;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Polling slots, lowest index wins a tie
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int LEVEL_W = 2;
  localparam int NUM_LEVELS = 4;
  localparam int SLOT_EXTINT0 = 0;
  localparam int SLOT_TIMER0 = 1;
  localparam int SLOT_EXTINT1 = 2;
  localparam int SLOT_TIMER1 = 3;
  localparam int SLOT_UART = 4;
  localparam int SLOT_DECODER = 5;
  localparam int SLOT_AUDIO = 6;
  localparam int SLOT_KEYPAD = 7;
  localparam int SLOT_TWO_WIRE = 8;
  localparam int SLOT_SERIAL_PERIPH = 9;
  localparam int SLOT_CARD = 10;
  localparam int SLOT_USB = 13;

endpackage

// *** iep_arb_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface iep_arb_if;
  logic [iep_pkg::NUM_SLOTS-1:0] req;
  logic [iep_pkg::NUM_SLOTS-1:0][iep_pkg::LEVEL_W-1:0] level;
  logic [iep_pkg::NUM_LEVELS-1:0] svc_active;
  logic grant;
  logic [iep_pkg::SLOT_W-1:0] slot;
  logic [iep_pkg::LEVEL_W-1:0] grant_level;

  modport ctrl (output req, output level, output svc_active, input grant, input slot, input grant_level);
  modport arb (input req, input level, input svc_active, output grant, output slot, output grant_level);
endinterface

`default_nettype wire

// *** iep_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none

module iep_arbiter (
  iep_arb_if.arb arb
);

  // Lowest level at which a request may preempt what is in service
  function automatic logic [iep_pkg::LEVEL_W:0] iep_ceiling(input logic [iep_pkg::NUM_LEVELS-1:0] act);
    logic [iep_pkg::LEVEL_W:0] c;
    c = '0;
    for (int l = 0; l < iep_pkg::NUM_LEVELS; l++) begin
      if (act[l]) begin
        c = (iep_pkg::LEVEL_W + 1)'(l + 1);
      end
    end
    return c;
  endfunction

  logic [iep_pkg::LEVEL_W:0] floor_lvl;
  logic found;
  logic [iep_pkg::SLOT_W-1:0] best_slot;
  logic [iep_pkg::LEVEL_W-1:0] best_lvl;

  always_comb begin
    floor_lvl = iep_ceiling(arb.svc_active);
    found = 1'b0;
    best_slot = '0;
    best_lvl = '0;
    // Strict compare keeps the earlier slot on an equal level
    for (int s = 0; s < iep_pkg::NUM_SLOTS; s++) begin
      if (arb.req[s] && ({1'b0, arb.level[s]} >= floor_lvl) &&
          (!found || arb.level[s] > best_lvl)) begin
        found = 1'b1;
        best_slot = iep_pkg::SLOT_W'(s);
        best_lvl = arb.level[s];
      end
    end
  end

  assign arb.grant = found;
  assign arb.slot = best_slot;
  assign arb.grant_level = best_lvl;

endmodule

`default_nettype wire

// *** iep_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module iep_src_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] want0,
  input wire logic [7:0] want1,
  output logic [6:0] group0_req,
  output logic [7:0] group1_req
);
  // Sources raise their request a clock after the bench asks; absent group-one sources stay low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      group0_req <= 7'h00;
      group1_req <= 8'h00;
    end else begin
      group0_req <= want0;
      group1_req <= want1 & 8'h57;
    end
  end
endmodule

`default_nettype wire

// *** iep_irq_regs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module iep_irq_regs_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rhit,
  input wire logic global_irq_enable,
  input wire logic [7:0] prio_lsb_group1,
  input wire logic [6:0] group0_req,
  input wire logic [7:0] group1_req,
  input wire logic [iep_pkg::NUM_LEVELS-1:0] svc_active,
  input wire logic [7:0] irq_enable_group1_out,
  input wire logic [7:0] prio_msb_group0_out,
  input wire logic [7:0] prio_msb_group1_out,
  input wire logic irq_pending,
  input wire logic [iep_pkg::SLOT_W-1:0] irq_slot,
  input wire logic [iep_pkg::LEVEL_W-1:0] irq_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // USB alone at level two, nothing in service
  sequence s_usb_only;
    global_irq_enable && irq_enable_group1_out[6] && prio_msb_group1_out[6] && !prio_lsb_group1[6]
      && group1_req == 8'h40 && group0_req == 7'h00 && svc_active == 4'h0;
  endsequence
  sequence s_usb_won;
    irq_pending && irq_slot == 4'hd && irq_level == 2'b10;
  endsequence
  chk_reset_clear: assert property (!$past(nrst) |-> irq_enable_group1_out == 8'h00
    && prio_msb_group0_out == 8'h00 && prio_msb_group1_out == 8'h00 && !irq_pending) else $error("reset values");
  chk_en_write: assert property (sfr_wr && sfr_addr == 8'hb1
    |=> irq_enable_group1_out == ($past(sfr_wdata) & 8'h57)) else $error("enable write");
  chk_msb1_write: assert property (sfr_wr && sfr_addr == 8'hb3
    |=> prio_msb_group1_out == ($past(sfr_wdata) & 8'h57)) else $error("msb1 write");
  chk_msb0_write: assert property (sfr_wr && sfr_addr == 8'hb7
    |=> prio_msb_group0_out == ($past(sfr_wdata) & 8'h7f)) else $error("msb0 write");
  chk_en_hold: assert property (!sfr_wr |=> $stable(irq_enable_group1_out)) else $error("enable drift");
  chk_unused_zero: assert property ((irq_enable_group1_out & 8'ha8) == 8'h00
    && (prio_msb_group1_out & 8'ha8) == 8'h00 && !prio_msb_group0_out[7]) else $error("unused bit set");
  chk_msb1_read: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'hb3
    |=> sfr_rhit && sfr_rdata == $past(prio_msb_group1_out)) else $error("msb1 read");
  chk_read_miss: assert property (sfr_rd && sfr_addr == 8'hb2
    |=> !sfr_rhit && sfr_rdata == 8'h00) else $error("unmapped read");
  chk_global_gate: assert property (!global_irq_enable |=> !irq_pending) else $error("global gate");
  chk_usb_mask: assert property (!irq_enable_group1_out[6] && group1_req == 8'h40
    && group0_req == 7'h00 |=> !irq_pending) else $error("usb mask");
  chk_usb_win: assert property (s_usb_only |=> s_usb_won) else $error("usb grant");
endmodule

bind iep_irq_regs iep_irq_regs_sva iep_irq_regs_sva_i (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rhit(sfr_rhit),
  .global_irq_enable(global_irq_enable), .prio_lsb_group1(prio_lsb_group1), .group0_req(group0_req),
  .group1_req(group1_req), .svc_active(svc_active), .irq_enable_group1_out(irq_enable_group1_out),
  .prio_msb_group0_out(prio_msb_group0_out), .prio_msb_group1_out(prio_msb_group1_out),
  .irq_pending(irq_pending), .irq_slot(irq_slot), .irq_level(irq_level));

`default_nettype wire

// *** test_iep_irq_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_iep_irq_regs;
  logic clk, nrst, sfr_wr, sfr_rd, sfr_rhit, glob, irq_pending;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, lsb0, lsb1, want1, g1, en1, msb0, msb1;
  logic [6:0] en0, want0, g0;
  logic [3:0] svc, irq_slot;
  logic [1:0] irq_level;
  int err_total = 0;
  int n_compared = 0;
  int bitv [5] = '{6, 4, 2, 1, 0};
  logic [3:0] slt [5] = '{4'hd, 4'h7, 4'h9, 4'h8, 4'ha};

  iep_src_model iep_src_model_i (.clk(clk), .nrst(nrst), .want0(want0), .want1(want1),
    .group0_req(g0), .group1_req(g1));
  iep_irq_regs iep_irq_regs_i (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rhit(sfr_rhit),
    .global_irq_enable(glob), .group0_irq_enable(en0), .prio_lsb_group0(lsb0), .prio_lsb_group1(lsb1),
    .group0_req(g0), .group1_req(g1), .svc_active(svc), .irq_enable_group1_out(en1),
    .prio_msb_group0_out(msb0), .prio_msb_group1_out(msb1), .irq_pending(irq_pending),
    .irq_slot(irq_slot), .irq_level(irq_level));

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk({sfr_rhit, 7'h00}, {hit, 7'h00});
    chk(sfr_rdata, exp);
  endtask
  // Request from the sources, then judge the winner two edges later
  task automatic go(input logic [7:0] w1, input logic [6:0] w0, input logic p, input logic [3:0] s,
    input logic [1:0] l);
    @(posedge clk);
    want1 <= w1;
    want0 <= w0;
    repeat (2) @(posedge clk);
    #1;
    chk({1'b0, irq_pending, p ? {irq_slot, irq_level} : 6'h00}, {1'b0, p, s, l});
    @(posedge clk);
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run is under 130 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    {nrst, sfr_wr, sfr_rd, glob, sfr_addr, sfr_wdata, lsb0, lsb1, want1, en0, want0, svc} <= '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(8'hb1, 8'h00, 1'b1);
    rd(8'hb3, 8'h00, 1'b1);
    rd(8'hb7, 8'h00, 1'b1);
    wr(8'hb1, 8'h57);
    wr(8'hb3, 8'h57);
    wr(8'hb7, 8'h7f);
    wr(8'hb2, 8'h57);
    rd(8'hb1, 8'h57, 1'b1);
    rd(8'hb3, 8'h57, 1'b1);
    rd(8'hb7, 8'h7f, 1'b1);
    rd(8'hb2, 8'h00, 1'b0);
    @(posedge clk);
    glob <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(8'hb1, 8'h01 << bitv[i]);
      go(8'h01 << bitv[i], 7'h00, 1'b1, slt[i], 2'b10);
      wr(8'hb1, 8'h57 & ~(8'h01 << bitv[i]));
      go(8'h01 << bitv[i], 7'h00, 1'b0, 4'h0, 2'b00);
    end
    glob <= 1'b0;
    go(8'h40, 7'h00, 1'b0, 4'h0, 2'b00);
    glob <= 1'b1;
    lsb1 <= 8'h40;
    wr(8'hb3, 8'h01);
    wr(8'hb1, 8'h57);
    go(8'h41, 7'h00, 1'b1, 4'ha, 2'b10);
    lsb1 <= 8'h41;
    go(8'h41, 7'h00, 1'b1, 4'ha, 2'b11);
    svc <= 4'h4;
    go(8'h41, 7'h00, 1'b1, 4'ha, 2'b11);
    svc <= 4'h8;
    go(8'h41, 7'h00, 1'b0, 4'h0, 2'b00);
    svc <= 4'h0;
    en0 <= 7'h7f;
    lsb0 <= 8'h02;
    wr(8'hb7, 8'h00);
    go(8'h00, 7'h03, 1'b1, 4'h1, 2'b01);
    lsb0 <= 8'h00;
    go(8'h00, 7'h03, 1'b1, 4'h0, 2'b00);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rd(8'hb1, 8'h00, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
